/* core/kds_pkg.sv */
// Shared constants and types for the keypad and display scan block.
// Assumes one 10 MHz core clock and a host reaching registers over a plain strobe port.
package kds_pkg;

    // Register offsets on the host port.
    localparam logic [2:0] KDS_OFF_DATA = 3'h0;      // FIFO, sensor or display data.
    localparam logic [2:0] KDS_OFF_STATUS = 3'h1;    // Status word, read only.
    localparam logic [2:0] KDS_OFF_MODE = 3'h2;      // Input mode, display format, entry side.
    localparam logic [2:0] KDS_OFF_CMD = 3'h3;       // One-shot command bits.
    localparam logic [2:0] KDS_OFF_ADDR = 3'h4;      // Read source, auto increment, RAM address.
    localparam logic [2:0] KDS_OFF_PRESC = 3'h5;     // Time base divisor.

    // Mode register field positions.
    localparam int KDS_MODE_IN_LSB = 0;              // Two bits of input mode.
    localparam int KDS_MODE_EIGHT = 2;               // One selects eight characters.
    localparam int KDS_MODE_RIGHT = 3;               // One selects right entry.

    // Command register bit positions.
    localparam int KDS_CMD_END_IRQ = 0;              // End interrupt.
    localparam int KDS_CMD_CLR_FIFO = 1;             // FIFO clear bit.
    localparam int KDS_CMD_CLR_DISP = 2;             // Clear display RAM.
    localparam int KDS_CMD_CLR_ALL = 3;              // Clear FIFO, status flags and display RAM, and resync timing.
    localparam int KDS_CMD_ERR_MODE = 4;             // Special error mode value.

    // Address register field positions.
    localparam int KDS_ADDR_SRC = 7;                 // One reads the display RAM.
    localparam int KDS_ADDR_AI = 6;                  // Auto-increment flag.

    // Status word bit positions; count uses bits 2 to 0.
    localparam int KDS_ST_UNAVAIL = 7;
    localparam int KDS_ST_SENS_ERR = 6;
    localparam int KDS_ST_OVERRUN = 5;
    localparam int KDS_ST_UNDERRUN = 4;
    localparam int KDS_ST_FULL = 3;

    // Divisor reset value and minimum.
    localparam logic [4:0] KDS_PRESC_RST = 5'h1F;
    localparam logic [4:0] KDS_PRESC_MIN = 5'h02;

    // Time base period and scan figures, in microseconds.
    localparam int KDS_TICK_US = 10;
    localparam int KDS_DIGIT_ON_US = 480;
    localparam int KDS_BLANK_US = 160;
    localparam int KDS_CLEAR_US = 160;
    localparam logic [5:0] KDS_ON_TICKS = 6'(KDS_DIGIT_ON_US / KDS_TICK_US);
    localparam logic [5:0] KDS_SLOT_TICKS = 6'((KDS_DIGIT_ON_US + KDS_BLANK_US) / KDS_TICK_US - 1);
    localparam logic [3:0] KDS_CLEAR_LAST = 4'((KDS_CLEAR_US / KDS_TICK_US) - 1);

    // Input modes.
    typedef enum logic [1:0] {
        KDS_IN_KEYS = 2'b00,
        KDS_IN_SENSOR = 2'b01,
        KDS_IN_STROBE = 2'b11
    } kds_in_mode_t;

endpackage : kds_pkg

/* core/kds_core.sv */
// Keypad and display scan core: sensor image, key FIFO, strobed input and display RAM.
// Assumes the host port is synchronous to core_clk_i and that scan pins come from outside.
`timescale 1ns/1ps

module kds_core
    import kds_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int DISP_CHARS = 16
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Host register port.
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Matrix and strobe pins.
    input wire logic [7:0] return_lines_i,
    input wire logic control_key_input_i,
    input wire logic modifier_key_input_i,
    output logic [3:0] scan_line_outputs_o,
    // Display pins.
    output logic [7:0] disp_data_o,
    output logic disp_blank_o,
    // Request to the host.
    output logic key_event_o
);

    // All state of the block in one record.
    typedef struct packed {
        logic [7:0] ret_s1;                // First synchroniser stage for returns.
        logic [7:0] ret_s2;                // Synchronised returns.
        logic [1:0] ctl_s;                 // Control input synchroniser, bit 1 is usable.
        logic [1:0] mod_s;                 // Modifier input synchroniser.
        logic ctl_prev;                    // Last synchronised control level.
        logic [1:0] in_mode;               // Input mode.
        logic eight;                       // Eight-character format.
        logic right;                       // Right entry.
        logic err_mode;                    // Special error mode.
        logic src_disp;                    // Data reads come from display RAM.
        logic ai;                          // Auto-increment flag.
        logic [3:0] disp_addr;             // Shared display read and write address.
        logic [2:0] sens_addr;             // Sensor RAM read row.
        logic [4:0] presc;                 // Time base divisor.
        logic [4:0] presc_cnt;             // Divider count.
        logic [5:0] slot;                  // Tick within a digit slot.
        logic [3:0] digit;                 // Current digit and scan row.
        logic [15:0][7:0] disp;            // Display RAM.
        logic [7:0][7:0] sens;             // Sensor RAM, also last key image.
        logic [7:0][7:0] fifo;             // Key FIFO storage.
        logic [2:0] rd_ptr;                // FIFO read index.
        logic [3:0] count;                 // FIFO fill level.
        logic overrun;                     // Sticky overrun.
        logic underrun;                    // Sticky underrun.
        logic multi_err;                   // Simultaneous closure error.
        logic changed;                     // Sensor change seen this scan.
        logic sens_req;                    // Sensor request line.
        logic inhibit;                     // Sensor writes held off.
        logic clearing;                    // Display clear in progress.
        logic [3:0] clr_idx;               // Next row to clear.
        logic [7:0] rdata;                 // Read data register.
        logic [7:0] disp_out;              // Display data register.
        logic blank;                       // Display blank register.
    } kds_state_t;

    kds_state_t q;                         // Registered state.
    kds_state_t d;                         // Next state.

    // Combinational helpers.
    logic tick;                            // One-cycle time base enable.
    logic [3:0] last_pos;                  // Rightmost display index.
    logic [7:0] new_close;                 // Closures new this row.
    logic [7:0] push_byte;                 // Byte offered to the FIFO.
    logic push;                            // Push request this cycle.
    logic pop;                             // Pop this cycle.
    logic [2:0] col;                       // Lowest new closure column.
    logic [2:0] wr_ptr;                    // FIFO write index.
    logic any_closure;                     // Any sensor bit closed.
    logic sample;                          // End of digit on time.

    // Next-state logic for the whole block.
    always_comb begin
        // Hold all state.
        d = q;
        // Idle strobes.
        tick = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        push_byte = 8'h00;
        col = 3'h0;
        // Next free slot.
        wr_ptr = 3'(q.rd_ptr + q.count[2:0]);
        // Rightmost index.
        last_pos = q.eight ? 4'h7 : 4'(DISP_CHARS - 1);
        any_closure = 1'b0;
        new_close = 8'h00;
        sample = 1'b0;

        // Synchronisers for the pins.
        d.ret_s1 = return_lines_i;
        d.ret_s2 = q.ret_s1;
        d.ctl_s = {q.ctl_s[0], control_key_input_i};
        d.mod_s = {q.mod_s[0], modifier_key_input_i};
        d.ctl_prev = q.ctl_s[1];

        // Time base divider; divisor below two is treated as two.
        if (q.presc_cnt >= ((q.presc < KDS_PRESC_MIN) ? KDS_PRESC_MIN : q.presc) - 5'h01) begin
            d.presc_cnt = 5'h00;
            // Divisor reached.
            tick = 1'b1;
        end else begin
            // Count on.
            d.presc_cnt = q.presc_cnt + 5'h01;
        end

        // Digit slot: on time then blanking, then the next digit.
        if (tick) begin
            if (q.slot == KDS_SLOT_TICKS) begin
                // Next digit.
                d.slot = 6'h00;
                d.digit = (q.digit == last_pos) ? 4'h0 : q.digit + 4'h1;
            end else begin
                // Same slot.
                d.slot = q.slot + 6'h01;
            end
            sample = (q.slot == KDS_ON_TICKS - 6'h01);
        end
        // Display drive is registered; blank outside on time.
        d.blank = (d.slot >= KDS_ON_TICKS);
        d.disp_out = d.blank ? 8'h00 : q.disp[d.digit];

        // Matrix sampling at the end of each row's on time.
        if (sample && q.in_mode == KDS_IN_SENSOR) begin
            // Raw levels, no debounce, control and modifier unused.
            if (!q.inhibit) begin
                d.sens[q.digit[2:0]] = q.ret_s2;
                if (q.ret_s2 != q.sens[q.digit[2:0]]) begin
                    d.changed = 1'b1;
                end
            end
            // End of a scan.
            if (q.digit[2:0] == 3'h7) begin
                if (d.changed) begin
                    d.sens_req = 1'b1;
                    d.inhibit = 1'b1;
                end
                // Fresh scan.
                d.changed = 1'b0;
            end
        end else if (sample && q.in_mode == KDS_IN_KEYS) begin
            // Closed keys pull a return low; a new closure enters the FIFO once.
            new_close = ~q.ret_s2 & q.sens[q.digit[2:0]];
            d.sens[q.digit[2:0]] = q.ret_s2;
            // Lowest column wins.
            for (int i = 7; i >= 0; i--) begin
                if (new_close[i]) begin
                    col = 3'(i);
                end
            end
            // One byte per row.
            if (new_close != 8'h00) begin
                push = 1'b1;
                push_byte = {q.ctl_s[1], q.mod_s[1], q.digit[2:0], col};
            end
            // Two closures in error mode: error.
            if (q.err_mode && (new_close & (new_close - 8'h01)) != 8'h00) begin
                d.multi_err = 1'b1;
            end
        end else if (q.in_mode == KDS_IN_STROBE && q.ctl_s[1] && !q.ctl_prev) begin
            push = 1'b1;
            push_byte = q.ret_s2;
        end

        // Host register writes.
        if (reg_wr_i) begin
            case (reg_addr_i)
                KDS_OFF_DATA: begin
                    // Writes are refused while the display is being cleared.
                    if (!q.clearing && q.right) begin
                        for (int i = 0; i < DISP_CHARS - 1; i++) begin
                            if (4'(i) < last_pos) begin
                                d.disp[i] = q.disp[i + 1];
                            end
                        end
                        d.disp[last_pos] = reg_wdata_i;
                    end else if (!q.clearing) begin
                        d.disp[q.disp_addr] = reg_wdata_i;
                        if (q.ai) begin
                            d.disp_addr = (q.disp_addr == last_pos) ? 4'h0 : q.disp_addr + 4'h1;
                        end
                    end
                end
                KDS_OFF_MODE: begin
                    // New mode.
                    d.in_mode = reg_wdata_i[KDS_MODE_IN_LSB +: 2];
                    d.eight = reg_wdata_i[KDS_MODE_EIGHT];
                    d.right = reg_wdata_i[KDS_MODE_RIGHT];
                end
                KDS_OFF_CMD: begin
                    if (reg_wdata_i[KDS_CMD_END_IRQ]) begin
                        d.sens_req = 1'b0;
                        d.inhibit = 1'b0;
                        d.err_mode = reg_wdata_i[KDS_CMD_ERR_MODE];
                    end
                    if (reg_wdata_i[KDS_CMD_CLR_FIFO] || reg_wdata_i[KDS_CMD_CLR_ALL]) begin
                        d.count = 4'h0;
                        d.overrun = 1'b0;
                        d.underrun = 1'b0;
                        // A set in this cycle wins.
                        d.multi_err = d.multi_err && !q.multi_err;
                        d.sens_req = 1'b0;
                        d.sens_addr = 3'h0;
                    end
                    if (reg_wdata_i[KDS_CMD_CLR_DISP] || reg_wdata_i[KDS_CMD_CLR_ALL]) begin
                        d.clearing = 1'b1;
                        d.clr_idx = 4'h0;
                    end
                    // Resync timing.
                    if (reg_wdata_i[KDS_CMD_CLR_ALL]) begin
                        d.slot = 6'h00;
                        d.digit = 4'h0;
                        d.presc_cnt = 5'h00;
                    end
                end
                KDS_OFF_ADDR: begin
                    // Both pointers.
                    d.src_disp = reg_wdata_i[KDS_ADDR_SRC];
                    d.ai = reg_wdata_i[KDS_ADDR_AI];
                    d.disp_addr = reg_wdata_i[3:0];
                    d.sens_addr = reg_wdata_i[2:0];
                end
                KDS_OFF_PRESC: begin
                    // Below two acts as two.
                    d.presc = reg_wdata_i[4:0];
                end
                default: begin
                    // Status and unmapped offsets ignore writes.
                end
            endcase
        end

        // Host register reads, answered in the next cycle.
        d.rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                KDS_OFF_DATA: begin
                    if (q.src_disp) begin
                        d.rdata = q.disp[q.disp_addr];
                        if (q.ai) begin
                            d.disp_addr = (q.disp_addr == last_pos) ? 4'h0 : q.disp_addr + 4'h1;
                        end
                    end else if (q.in_mode == KDS_IN_SENSOR) begin
                        d.rdata = q.sens[q.sens_addr];
                        if (q.ai) begin
                            d.sens_addr = q.sens_addr + 3'h1;
                        end else if (q.inhibit || !d.inhibit) begin
                            // A raise in this cycle wins.
                            d.sens_req = 1'b0;
                        end
                    end else if (q.count == 4'h0) begin
                        d.underrun = 1'b1;
                    end else begin
                        // Oldest first.
                        d.rdata = q.fifo[q.rd_ptr];
                        pop = 1'b1;
                    end
                end
                KDS_OFF_STATUS: begin
                    // Zero bit: closure.
                    for (int r = 0; r < 8; r++) begin
                        any_closure = any_closure | (q.sens[r] != 8'hFF);
                    end
                    d.rdata[KDS_ST_UNAVAIL] = q.clearing;
                    d.rdata[KDS_ST_SENS_ERR] = (q.in_mode == KDS_IN_SENSOR) ? any_closure : q.multi_err;
                    d.rdata[KDS_ST_OVERRUN] = q.overrun;
                    d.rdata[KDS_ST_UNDERRUN] = q.underrun;
                    d.rdata[KDS_ST_FULL] = (q.count == 4'(FIFO_DEPTH));
                    d.rdata[2:0] = q.count[2:0];
                end
                KDS_OFF_MODE: begin
                    d.rdata = {4'h0, q.right, q.eight, q.in_mode};
                end
                KDS_OFF_ADDR: begin
                    d.rdata = {q.src_disp, q.ai, 2'h0, q.disp_addr};
                end
                KDS_OFF_PRESC: begin
                    d.rdata = {3'h0, q.presc};
                end
                default: begin
                    d.rdata = 8'h00;
                end
            endcase
        end

        // FIFO update; a push into a full FIFO without a pop in the same cycle is dropped and flagged.
        if (push && (q.multi_err || d.count == 4'h0 && !(q.count == 4'h0))) begin
            push = 1'b0;
            // Lost byte on full.
            d.overrun = d.overrun || q.count == 4'(FIFO_DEPTH);
        end
        if (push) begin
            if (q.count == 4'(FIFO_DEPTH) && !pop) begin
                d.overrun = 1'b1;
            end else begin
                d.fifo[wr_ptr] = push_byte;
                d.count = q.count + 4'h1;
            end
        end
        // Pop frees a slot.
        if (pop) begin
            d.rd_ptr = q.rd_ptr + 3'h1;
            d.count = (push && d.count != q.count) ? q.count : q.count - 4'h1;
        end

        // Display clear, one row per tick, writes held off meanwhile.
        if (q.clearing && tick) begin
            // One row per tick.
            d.disp[q.clr_idx] = 8'h00;
            d.clr_idx = q.clr_idx + 4'h1;
            if (q.clr_idx == KDS_CLEAR_LAST) begin
                d.clearing = 1'b0;
            end
        end
    end

    // State register.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.presc <= KDS_PRESC_RST;
            q.sens <= {8{8'hFF}};
            q.blank <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs.
    assign reg_rdata_o = q.rdata;
    assign scan_line_outputs_o = q.digit;
    assign disp_data_o = q.disp_out;
    assign disp_blank_o = q.blank;
    // Level request.
    assign key_event_o = (q.in_mode == KDS_IN_SENSOR) ? q.sens_req : (q.count != 4'h0 || q.multi_err);

endmodule : kds_core

/* bench/kds_core_props.sv */
// Checker for the scan core: host port answers, blanking and request line.
// Assumes one clock domain and the field layout of kds_pkg.
`timescale 1ns/1ps
module kds_core_props
    import kds_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Host port.
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // Display and request pins.
    input wire logic [7:0] disp_data_o,
    input wire logic disp_blank_o,
    input wire logic key_event_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic sens_q; // Sensor mode is selected.
    logic auto_inc_q; // Auto-increment flag.
    logic src_q; // Data reads come from the display.
    logic rd_q; // A read was taken last edge.
    logic st_q; // A status read was taken last edge.
    logic dat_rd; // Data read from the sensor image or the FIFO.
    assign dat_rd = reg_rd_i && reg_addr_i == KDS_OFF_DATA && !src_q;
    // Mirror the host's mode and address writes.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {sens_q, auto_inc_q, src_q, rd_q, st_q} <= 5'h00;
        end else begin
            rd_q <= reg_rd_i;
            st_q <= reg_rd_i && reg_addr_i == KDS_OFF_STATUS;
            if (reg_wr_i && reg_addr_i == KDS_OFF_MODE) begin
                sens_q <= reg_wdata_i[1:0] == KDS_IN_SENSOR;
            end
            if (reg_wr_i && reg_addr_i == KDS_OFF_ADDR) begin
                {src_q, auto_inc_q} <= reg_wdata_i[7:6];
            end
        end
    end
    blank_data_zero_a: assert property (disp_blank_o |-> disp_data_o == 8'h00)
        else $error("Display data not zero while blanked.");
    blank_hold_a: assert property ($rose(disp_blank_o) |-> disp_blank_o [*8])
        else $error("Blanking interval too short.");
    digit_on_hold_a: assert property ($fell(disp_blank_o) |-> !disp_blank_o [*8])
        else $error("Digit on time too short.");
    rdata_idle_a: assert property (!rd_q |-> reg_rdata_o == 8'h00)
        else $error("Read data not zero outside a read answer.");
    full_count_a: assert property (st_q && reg_rdata_o[KDS_ST_FULL] |-> reg_rdata_o[2:0] == 3'h0)
        else $error("Full FIFO shows a nonzero count.");
    status_event_a: assert property (st_q && !sens_q && reg_rdata_o[3:0] != 4'h0 |-> key_event_o)
        else $error("FIFO holds characters but request is low.");
    unavail_a: assert property (reg_wr_i && reg_addr_i == KDS_OFF_CMD && reg_wdata_i[KDS_CMD_CLR_DISP]
        ##[1:2] reg_rd_i && reg_addr_i == KDS_OFF_STATUS |=> reg_rdata_o[KDS_ST_UNAVAIL])
        else $error("Unavailable bit missing during clear.");
    read_clear_a: assert property (sens_q && !auto_inc_q && key_event_o && dat_rd |-> ##[1:3] !key_event_o)
        else $error("Data read did not clear the sensor request.");
    auto_inc_hold_a: assert property (sens_q && auto_inc_q && key_event_o && dat_rd |=> key_event_o)
        else $error("Data read cleared the request with auto-increment set.");
    end_irq_a: assert property (sens_q && reg_wr_i && reg_addr_i == KDS_OFF_CMD
        && reg_wdata_i[KDS_CMD_END_IRQ] |-> ##[1:3] !key_event_o)
        else $error("End command did not lower the request.");
endmodule // kds_core_props

bind kds_core kds_core_props u_props (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .disp_data_o(disp_data_o), .disp_blank_o(disp_blank_o), .key_event_o(key_event_o));

/* bench/kds_matrix_model.sv */
// Switch matrix and strobed byte source facing the scan pins.
// Assumes the low three scan bits pick the row and the return lines are pulled up.
`timescale 1ns/1ps
module kds_matrix_model (
    // Scan side.
    input wire logic [3:0] scan_line_outputs_i,
    // Closed switches, bit row times eight plus column.
    input wire logic [63:0] closed_i,
    // Strobed byte source.
    input wire logic strobe_sel_i,
    input wire logic [7:0] strobe_data_i,
    // Return pins.
    output logic [7:0] return_lines_o
);
    // A closed switch pulls its return low on the driven row; open lines sit at the pull-up.
    always_comb begin
        return_lines_o = ~closed_i[{scan_line_outputs_i[2:0], 3'h0} +: 8];
        if (strobe_sel_i) begin
            return_lines_o = strobe_data_i;
        end
    end
endmodule // kds_matrix_model

/* bench/tb_keypad_display_scan_entry.sv */
// Self-checking bench for the scan core: display entry, FIFO, strobe, keys and sensor image.
// Assumes a 10 MHz clock and divisor 2, so one full display scan is 2048 clocks.
`timescale 1ns/1ps
module tb_keypad_display_scan_entry;
    import kds_pkg::*;
    logic clk, rst_n, wr, rd, ctl, mdf, blank, kev, ssel;
    logic [2:0] addr;
    logic [3:0] scan;
    logic [7:0] wdata, rdata, ret, sdata, dsp, rv;
    logic [63:0] closed;
    int errors, n_tests, i;
    kds_core #(.FIFO_DEPTH(8), .DISP_CHARS(16)) DUT (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .return_lines_i(ret),
        .control_key_input_i(ctl), .modifier_key_input_i(mdf), .scan_line_outputs_o(scan),
        .disp_data_o(dsp), .disp_blank_o(blank), .key_event_o(kev));
    kds_matrix_model PART (.scan_line_outputs_i(scan), .closed_i(closed), .strobe_sel_i(ssel),
        .strobe_data_i(sdata), .return_lines_o(ret));
    // Free-running core clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("Checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Compares one byte and counts it.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One-cycle register write.
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // One-cycle read; the answer stands only in the following cycle.
    task automatic rd_reg(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask
    // Reads a register and compares it.
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp, input string what);
        rd_reg(a);
        chk(what, exp, rv);
    endtask
    // Waits, bounded, for the request line to reach a level.
    task automatic wait_kev(input logic lvl);
        for (int k = 0; k < 9000 && kev !== lvl; k++) @(posedge clk) #1;
        chk("request level", {7'h00, lvl}, {7'h00, kev});
        if (kev !== lvl) final_report();
    endtask
    // Waits, bounded, for a lit digit and compares its data.
    task automatic dig(input logic [3:0] d, input logic [7:0] exp);
        for (int k = 0; k < 9000 && !(scan === d && blank === 1'b0); k++) @(posedge clk) #1;
        chk("digit data", exp, dsp);
        chk("digit lit", {4'h0, d}, {3'h0, blank, scan});
        if (scan !== d || blank !== 1'b0) final_report();
    endtask
    // Presents a byte and pulses the strobe, holding the byte across the edge.
    task automatic strobe(input logic [7:0] d);
        @(posedge clk);
        sdata <= d;
        repeat (3) @(posedge clk);
        ctl <= 1'b1;
        repeat (6) @(posedge clk);
        ctl <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // Main sequence.
    initial begin
        {rst_n, wr, rd, ctl, mdf, ssel} = 6'h00;
        {addr, wdata, sdata, closed} = '0;
        {errors, n_tests} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rchk(KDS_OFF_STATUS, 8'h00, "reset status");
        rchk(3'h6, 8'h00, "unmapped read");
        wr_reg(KDS_OFF_PRESC, {3'h0, KDS_PRESC_MIN});
        $display("Done: reset");
        wr_reg(KDS_OFF_ADDR, 8'hCE);
        for (i = 0; i < 3; i++) wr_reg(KDS_OFF_DATA, 8'hA1 + 8'(i));
        wr_reg(KDS_OFF_ADDR, 8'hCE);
        rchk(KDS_OFF_DATA, 8'hA1, "char 14");
        rchk(KDS_OFF_DATA, 8'hA2, "char 15");
        rchk(KDS_OFF_DATA, 8'hA3, "char 0 after wrap");
        dig(4'hF, 8'hA2);
        dig(4'h0, 8'hA3);
        wr_reg(KDS_OFF_ADDR, 8'h85);
        wr_reg(KDS_OFF_DATA, 8'h11);
        wr_reg(KDS_OFF_DATA, 8'h22);
        rchk(KDS_OFF_DATA, 8'h22, "same address");
        wr_reg(KDS_OFF_MODE, 8'h04);
        wr_reg(KDS_OFF_ADDR, 8'hC7);
        wr_reg(KDS_OFF_DATA, 8'hB1);
        wr_reg(KDS_OFF_DATA, 8'hB2);
        wr_reg(KDS_OFF_ADDR, 8'h80);
        rchk(KDS_OFF_DATA, 8'hB2, "ninth char");
        wr_reg(KDS_OFF_MODE, 8'h08);
        wr_reg(KDS_OFF_ADDR, 8'hC0);
        wr_reg(KDS_OFF_DATA, 8'hC1);
        wr_reg(KDS_OFF_DATA, 8'hC2);
        dig(4'hF, 8'hC2);
        dig(4'hE, 8'hC1);
        $display("Done: display entry");
        wr_reg(KDS_OFF_CMD, 8'h04);
        rchk(KDS_OFF_STATUS, 8'h80, "busy status");
        repeat (40) @(posedge clk);
        rchk(KDS_OFF_STATUS, 8'h00, "free status");
        wr_reg(KDS_OFF_ADDR, 8'h80);
        rchk(KDS_OFF_DATA, 8'h00, "cleared char");
        $display("Done: clear");
        wr_reg(KDS_OFF_MODE, 8'h03);
        wr_reg(KDS_OFF_ADDR, 8'h00);
        ssel <= 1'b1;
        for (i = 0; i < 9; i++) strobe(8'h30 + 8'(i));
        rchk(KDS_OFF_STATUS, 8'h28, "full and overrun");
        for (i = 0; i < 8; i++) rchk(KDS_OFF_DATA, 8'h30 + 8'(i), "fifo byte");
        rd_reg(KDS_OFF_DATA);
        rchk(KDS_OFF_STATUS, 8'h30, "underrun kept");
        wr_reg(KDS_OFF_CMD, 8'h02);
        rchk(KDS_OFF_STATUS, 8'h00, "errors cleared");
        ssel <= 1'b0;
        $display("Done: strobed FIFO");
        wr_reg(KDS_OFF_MODE, 8'h00);
        ctl <= 1'b1;
        closed <= 64'h1 << 21;
        wait_kev(1'b1);
        rchk(KDS_OFF_DATA, 8'h95, "key code");
        wr_reg(KDS_OFF_CMD, 8'h11);
        closed <= 64'h3 << 32;
        wait_kev(1'b1);
        rchk(KDS_OFF_STATUS, 8'h41, "multi closure");
        closed <= 64'h0;
        repeat (2100) @(posedge clk);
        wr_reg(KDS_OFF_CMD, 8'h02);
        $display("Done: keys");
        wr_reg(KDS_OFF_MODE, 8'h01);
        wr_reg(KDS_OFF_ADDR, 8'h03);
        mdf <= 1'b1;
        closed <= 64'h1 << 25;
        wait_kev(1'b1);
        rchk(KDS_OFF_STATUS, 8'h40, "closure bit");
        rchk(KDS_OFF_DATA, 8'hFD, "sensor row");
        closed <= 64'h0;
        repeat (2200) @(posedge clk);
        chk("inhibited request", 8'h00, {7'h00, kev});
        wr_reg(KDS_OFF_CMD, 8'h01);
        wait_kev(1'b1);
        wr_reg(KDS_OFF_ADDR, 8'h43);
        rchk(KDS_OFF_DATA, 8'hFF, "released row");
        chk("request kept", 8'h01, {7'h00, kev});
        wr_reg(KDS_OFF_CMD, 8'h01);
        wait_kev(1'b0);
        $display("Done: sensor");
        final_report();
    end
endmodule // tb_keypad_display_scan_entry
